// ===== inc/display_map_pkg.sv
// shared constants for the frame memory, address counter and panel scan
// assumes a 32-bit ahb-lite register bus and one 200 MHz clock
package display_map_pkg;
   localparam int PIX_W = 18;
   localparam int COORD_W = 9;
   localparam int ADDR_W = 17;
   localparam int FIFO_DEPTH = 8;
   localparam int MEM_WORDS = 103680;
   localparam logic [ADDR_W-1:0] COLS = 17'h000F0;
   localparam logic [COORD_W-1:0] COL_MAX = 9'h0EF;
   localparam logic [COORD_W-1:0] ROW_MAX = 9'h1AF;
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_TFA_HI = 6'h0E;
   localparam logic [5:0] IDX_TFA_LO = 6'h0F;
   localparam logic [5:0] IDX_VSA_HI = 6'h10;
   localparam logic [5:0] IDX_VSA_LO = 6'h11;
   localparam logic [5:0] IDX_BFA_HI = 6'h12;
   localparam logic [5:0] IDX_BFA_LO = 6'h13;
   localparam logic [5:0] IDX_VSP_HI = 6'h14;
   localparam logic [5:0] IDX_VSP_LO = 6'h15;
   localparam logic [5:0] IDX_CTRL = 6'h20;
   localparam logic [5:0] IDX_COL_START = 6'h21;
   localparam logic [5:0] IDX_COL_END = 6'h22;
   localparam logic [5:0] IDX_ROW_START = 6'h23;
   localparam logic [5:0] IDX_ROW_END = 6'h24;
   localparam logic [5:0] IDX_PART_START = 6'h25;
   localparam logic [5:0] IDX_PART_END = 6'h26;
   localparam logic [5:0] IDX_PIXEL = 6'h27;
   localparam logic [5:0] IDX_STATUS = 6'h28;
   // control register fields
   localparam int CTRL_W = 7;
   localparam int BIT_EXCHANGE = 0;
   localparam int BIT_COL_MIRROR = 1;
   localparam int BIT_ROW_MIRROR = 2;
   localparam int BIT_SCAN_DIR = 3;
   localparam int BIT_RB_SWAP = 4;
   localparam int BIT_PARTIAL = 5;
   localparam int BIT_SCROLL = 6;
   // status register fields
   localparam int STAT_BUSY = 31;
   localparam int STAT_X_LSB = 16;
   localparam int STAT_Y_LSB = 0;
   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [COORD_W-1:0] WIN_START_RST = 9'h000;
   localparam logic [COORD_W-1:0] COL_END_RST = 9'h0EF;
   localparam logic [COORD_W-1:0] ROW_END_RST = 9'h1AF;
   localparam logic [15:0] PART_START_RST = 16'h0000;
   localparam logic [15:0] PART_END_RST = 16'h01AF;
   localparam logic [15:0] TFA_RST = 16'h0000;
   localparam logic [15:0] VSA_RST = 16'h01B0;
   localparam logic [15:0] BFA_RST = 16'h0000;
   localparam logic [15:0] VSP_RST = 16'h0000;
endpackage

// ===== inc/pixel_stream_if.sv
// valid/ready pixel stream between the register front end, the fifo and the writer
// assumes one clock domain; a word moves when valid and ready are both high
`timescale 1ns/10ps
`default_nettype none
interface pixel_stream_if #(parameter int WIDTH = 18) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== design/pixel_fifo.sv
// small synchronous fifo with honest full and empty
// assumes depth is a power of two
`timescale 1ns/10ps
`default_nettype none
module pixel_fifo #(parameter int WIDTH = 18, parameter int DEPTH = 8) (
   input wire logic clk,
   input wire logic arst_n,
   pixel_stream_if.snk fill,
   pixel_stream_if.src drain
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [PW:0] count_q, count_d;
   logic push, pop;

   assign fill.ready = (count_q != FULL);
   assign drain.valid = (count_q != '0);
   assign drain.data = store[rdPtr_q];
   assign push = fill.valid & fill.ready;
   assign pop = drain.valid & drain.ready;

   always_comb begin
      wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         store[wrPtr_q] <= fill.data;
      end
   end
endmodule // pixel_fifo
`default_nettype wire

// ===== design/frame_store.sv
// pixel frame memory with one write port and one registered scan read port
// assumes the writer and the scan may hit one word in the same cycle
`timescale 1ns/10ps
`default_nettype none
module frame_store
   import display_map_pkg::*;
(
   input wire logic clk,
   input wire logic writeEn,
   input wire logic [ADDR_W-1:0] writeAddr,
   input wire logic [PIX_W-1:0] writeData,
   input wire logic [ADDR_W-1:0] readAddr,
   output logic [PIX_W-1:0] readData
);
   logic [PIX_W-1:0] pixels [0:MEM_WORDS-1];

   // separate ports: neither side ever waits on the other
   always_ff @(posedge clk) begin
      if (writeEn) begin
         pixels[writeAddr] <= writeData;
      end
      readData <= pixels[readAddr];
   end
endmodule // frame_store
`default_nettype wire

// ===== design/frame_memory_address_counter.sv
// ahb-lite slave that fills the frame memory through a windowed address counter
// and scans it out to the panel with partial, scroll and orientation options
// assumes one 200 MHz clock; software polls the busy bit before moving the window
`timescale 1ns/10ps
`default_nettype none
module frame_memory_address_counter
   import display_map_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [PIX_W-1:0] scanPixel,
   output logic [COORD_W-1:0] scanGate,
   output logic [7:0] scanCol,
   output logic scanShow,
   output logic scanFirst
);
   // ************************************************************
   // bus front end
   // ************************************************************
   logic dphValid_q, dphValid_d, dphWrite_q, dphWrite_d;
   logic dphMapped_q, dphMapped_d;
   logic [5:0] dphIdx_q, dphIdx_d;
   logic hreadyout_q, hreadyout_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic hresp_q;
   logic holdValid_q, holdValid_d;
   logic [PIX_W-1:0] hold_q, hold_d;
   logic accept, dphDone, wrDone, pixWr, cfgWr, holdPop, addrMapped;
   logic [5:0] addrIdx;
   logic [31:0] readMux;

   // ************************************************************
   // configuration
   // ************************************************************
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [COORD_W-1:0] colStart_q, colStart_d, colEnd_q, colEnd_d;
   logic [COORD_W-1:0] rowStart_q, rowStart_d, rowEnd_q, rowEnd_d;
   logic [15:0] partStart_q, partStart_d, partEnd_q, partEnd_d;
   logic [15:0] topFixed_q, topFixed_d, scrollArea_q, scrollArea_d;
   logic [15:0] bottomFixed_q, bottomFixed_d, scrollStart_q, scrollStart_d;
   logic axisExchange, columnMirror, rowMirror, scanDirection;
   logic redBlueSwap, partialModeOn, scrollEnable;

   // ************************************************************
   // address counter and writer
   // ************************************************************
   logic [COORD_W-1:0] curX_q, curX_d, curY_q, curY_d;
   logic [COORD_W-1:0] physCol, physRow;
   logic [ADDR_W-1:0] writeAddr;
   logic memWe, winWr;

   // ************************************************************
   // panel scan
   // ************************************************************
   logic [COORD_W-1:0] gate_q, gate_d, gate1_q, gate1_d;
   logic [7:0] col_q, col_d, col1_q, col1_d;
   logic show1_q, show1_d, first1_q, first1_d;
   logic [PIX_W-1:0] scanPixel_q, scanPixel_d, memData;
   logic [COORD_W-1:0] scanGate_q;
   logic [7:0] scanCol_q;
   logic scanShow_q, scanFirst_q;
   logic [COORD_W-1:0] line, memRow;
   logic [9:0] scrollEnd, rowSum;
   logic [ADDR_W-1:0] readAddr;

   pixel_stream_if #(.WIDTH(PIX_W)) fillIf ();
   pixel_stream_if #(.WIDTH(PIX_W)) drainIf ();

   assign axisExchange = ctrl_q[BIT_EXCHANGE];
   assign columnMirror = ctrl_q[BIT_COL_MIRROR];
   assign rowMirror = ctrl_q[BIT_ROW_MIRROR];
   assign scanDirection = ctrl_q[BIT_SCAN_DIR];
   assign redBlueSwap = ctrl_q[BIT_RB_SWAP];
   assign partialModeOn = ctrl_q[BIT_PARTIAL];
   assign scrollEnable = ctrl_q[BIT_SCROLL];

   assign addrIdx = haddr[7:2];
   assign addrMapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) &&
      (((addrIdx >= IDX_TFA_HI) && (addrIdx <= IDX_VSP_LO)) ||
       ((addrIdx >= IDX_CTRL) && (addrIdx <= IDX_STATUS)));
   assign accept = hsel & htrans[1] & hready;
   assign dphDone = dphValid_q & hreadyout_q;
   assign wrDone = dphDone & dphWrite_q & dphMapped_q;
   assign pixWr = wrDone & (dphIdx_q == IDX_PIXEL);
   assign cfgWr = wrDone & (dphIdx_q != IDX_PIXEL);
   assign winWr = cfgWr & (dphIdx_q >= IDX_COL_START) & (dphIdx_q <= IDX_ROW_END);
   assign holdPop = holdValid_q & fillIf.ready;

   assign fillIf.valid = holdValid_q;
   assign fillIf.data = hold_q;
   // any register write other than a pixel write this cycle stalls the writer one cycle, since a window change reloads the counter
   assign drainIf.ready = ~cfgWr;
   assign memWe = drainIf.valid & drainIf.ready;

   always_comb begin
      readMux = 32'h00000000;
      unique case (addrIdx)
         IDX_TFA_HI: readMux[7:0] = topFixed_q[15:8];
         IDX_TFA_LO: readMux[7:0] = topFixed_q[7:0];
         IDX_VSA_HI: readMux[7:0] = scrollArea_q[15:8];
         IDX_VSA_LO: readMux[7:0] = scrollArea_q[7:0];
         IDX_BFA_HI: readMux[7:0] = bottomFixed_q[15:8];
         IDX_BFA_LO: readMux[7:0] = bottomFixed_q[7:0];
         IDX_VSP_HI: readMux[7:0] = scrollStart_q[15:8];
         IDX_VSP_LO: readMux[7:0] = scrollStart_q[7:0];
         IDX_CTRL: readMux[CTRL_W-1:0] = ctrl_q;
         IDX_COL_START: readMux[COORD_W-1:0] = colStart_q;
         IDX_COL_END: readMux[COORD_W-1:0] = colEnd_q;
         IDX_ROW_START: readMux[COORD_W-1:0] = rowStart_q;
         IDX_ROW_END: readMux[COORD_W-1:0] = rowEnd_q;
         IDX_PART_START: readMux[15:0] = partStart_q;
         IDX_PART_END: readMux[15:0] = partEnd_q;
         IDX_PIXEL: readMux[PIX_W-1:0] = hold_q;
         IDX_STATUS: begin
            readMux[STAT_BUSY] = holdValid_q | drainIf.valid;
            readMux[STAT_X_LSB +: COORD_W] = curX_q;
            readMux[STAT_Y_LSB +: COORD_W] = curY_q;
         end
         default: readMux = 32'h00000000;
      endcase
   end

   always_comb begin
      dphValid_d = dphValid_q;
      dphWrite_d = dphWrite_q;
      dphMapped_d = dphMapped_q;
      dphIdx_d = dphIdx_q;
      hrdata_d = hrdata_q;
      if (accept) begin
         dphValid_d = 1'b1;
         dphWrite_d = hwrite;
         dphMapped_d = addrMapped;
         dphIdx_d = addrIdx;
         hrdata_d = addrMapped ? readMux : 32'h00000000;
      end else if (dphDone) begin
         dphValid_d = 1'b0;
      end
      hold_d = pixWr ? hwdata[PIX_W-1:0] : hold_q;
      holdValid_d = (holdValid_q & ~holdPop) | pixWr;
      // an occupied holding word holds the next pixel data phase until it drains into the fifo
      hreadyout_d = ~(dphValid_d & dphWrite_d & dphMapped_d &
         (dphIdx_d == IDX_PIXEL) & holdValid_d);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dphValid_q <= 1'b0;
         dphWrite_q <= 1'b0;
         dphMapped_q <= 1'b0;
         dphIdx_q <= 6'h00;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
         hold_q <= '0;
         holdValid_q <= 1'b0;
      end else begin
         dphValid_q <= dphValid_d;
         dphWrite_q <= dphWrite_d;
         dphMapped_q <= dphMapped_d;
         dphIdx_q <= dphIdx_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= hreadyout_d;
         hresp_q <= 1'b0;
         hold_q <= hold_d;
         holdValid_q <= holdValid_d;
      end
   end

   always_comb begin
      ctrl_d = ctrl_q;
      colStart_d = colStart_q;
      colEnd_d = colEnd_q;
      rowStart_d = rowStart_q;
      rowEnd_d = rowEnd_q;
      partStart_d = partStart_q;
      partEnd_d = partEnd_q;
      topFixed_d = topFixed_q;
      scrollArea_d = scrollArea_q;
      bottomFixed_d = bottomFixed_q;
      scrollStart_d = scrollStart_q;
      if (cfgWr) begin
         unique case (dphIdx_q)
            IDX_TFA_HI: topFixed_d[15:8] = hwdata[7:0];
            IDX_TFA_LO: topFixed_d[7:0] = hwdata[7:0];
            IDX_VSA_HI: scrollArea_d[15:8] = hwdata[7:0];
            IDX_VSA_LO: scrollArea_d[7:0] = hwdata[7:0];
            IDX_BFA_HI: bottomFixed_d[15:8] = hwdata[7:0];
            IDX_BFA_LO: bottomFixed_d[7:0] = hwdata[7:0];
            IDX_VSP_HI: scrollStart_d[15:8] = hwdata[7:0];
            IDX_VSP_LO: scrollStart_d[7:0] = hwdata[7:0];
            IDX_CTRL: ctrl_d = hwdata[CTRL_W-1:0];
            IDX_COL_START: colStart_d = hwdata[COORD_W-1:0];
            IDX_COL_END: colEnd_d = hwdata[COORD_W-1:0];
            IDX_ROW_START: rowStart_d = hwdata[COORD_W-1:0];
            IDX_ROW_END: rowEnd_d = hwdata[COORD_W-1:0];
            IDX_PART_START: partStart_d = hwdata[15:0];
            IDX_PART_END: partEnd_d = hwdata[15:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= CTRL_RST;
         colStart_q <= WIN_START_RST;
         colEnd_q <= COL_END_RST;
         rowStart_q <= WIN_START_RST;
         rowEnd_q <= ROW_END_RST;
         partStart_q <= PART_START_RST;
         partEnd_q <= PART_END_RST;
         topFixed_q <= TFA_RST;
         scrollArea_q <= VSA_RST;
         bottomFixed_q <= BFA_RST;
         scrollStart_q <= VSP_RST;
      end else begin
         ctrl_q <= ctrl_d;
         colStart_q <= colStart_d;
         colEnd_q <= colEnd_d;
         rowStart_q <= rowStart_d;
         rowEnd_q <= rowEnd_d;
         partStart_q <= partStart_d;
         partEnd_q <= partEnd_d;
         topFixed_q <= topFixed_d;
         scrollArea_q <= scrollArea_d;
         bottomFixed_q <= bottomFixed_d;
         scrollStart_q <= scrollStart_d;
      end
   end

   // ************************************************************
   // host coordinates to physical memory address
   // ************************************************************
   always_comb begin
      if (axisExchange) begin
         physRow = rowMirror ? ROW_MAX - curX_q : curX_q;
         physCol = columnMirror ? COL_MAX - curY_q : curY_q;
      end else begin
         physCol = columnMirror ? COL_MAX - curX_q : curX_q;
         physRow = rowMirror ? ROW_MAX - curY_q : curY_q;
      end
   end

   assign writeAddr = ADDR_W'(physRow) * COLS + ADDR_W'(physCol);

   // counter always runs forward in host space; the mapping above picks direction
   always_comb begin
      curX_d = curX_q;
      curY_d = curY_q;
      if (winWr) begin
         curX_d = colStart_d;
         curY_d = rowStart_d;
      end else if (memWe) begin
         if (curX_q == colEnd_q) begin
            curX_d = colStart_q;
            curY_d = (curY_q == rowEnd_q) ? rowStart_q : curY_q + 1'b1;
         end else begin
            curX_d = curX_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         curX_q <= WIN_START_RST;
         curY_q <= WIN_START_RST;
      end else begin
         curX_q <= curX_d;
         curY_q <= curY_d;
      end
   end

   pixel_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .fill(fillIf),
      .drain(drainIf)
   );

   frame_store u_store (
      .clk(clk),
      .writeEn(memWe),
      .writeAddr(writeAddr),
      .writeData(drainIf.data),
      .readAddr(readAddr),
      .readData(memData)
   );

   // ************************************************************
   // panel scan: one pixel per clock, two cycles to the outputs
   // ************************************************************
   assign line = scanDirection ? ROW_MAX - gate_q : gate_q;
   assign scrollEnd = 10'(topFixed_q) + 10'(scrollArea_q);
   assign rowSum = 10'(scrollStart_q) + 10'(line) - 10'(topFixed_q);

   // unbalanced scroll counts give an undefined picture but never an illegal address
   always_comb begin
      memRow = line;
      if (scrollEnable && (10'(line) >= 10'(topFixed_q)) && (10'(line) < scrollEnd)) begin
         memRow = (rowSum >= scrollEnd) ? COORD_W'(rowSum - 10'(scrollArea_q))
                                        : COORD_W'(rowSum);
      end
      if (memRow > ROW_MAX) begin
         memRow = ROW_MAX;
      end
   end

   assign readAddr = ADDR_W'(memRow) * COLS + ADDR_W'(col_q);

   always_comb begin
      gate_d = gate_q;
      col_d = col_q + 1'b1;
      if (col_q == COL_MAX[7:0]) begin
         col_d = 8'h00;
         gate_d = (gate_q == ROW_MAX) ? 9'h000 : gate_q + 1'b1;
      end
      gate1_d = line;
      col1_d = col_q;
      show1_d = ~partialModeOn |
         ((16'(line) >= partStart_q) && (16'(line) <= partEnd_q));
      first1_d = (gate_q == 9'h000) && (col_q == 8'h00);
      scanPixel_d = 18'h00000;
      if (show1_q) begin
         scanPixel_d = redBlueSwap ? {memData[5:0], memData[11:6], memData[17:12]}
                                   : memData;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_q <= 9'h000;
         col_q <= 8'h00;
         gate1_q <= 9'h000;
         col1_q <= 8'h00;
         show1_q <= 1'b0;
         first1_q <= 1'b0;
         scanPixel_q <= 18'h00000;
         scanGate_q <= 9'h000;
         scanCol_q <= 8'h00;
         scanShow_q <= 1'b0;
         scanFirst_q <= 1'b0;
      end else begin
         gate_q <= gate_d;
         col_q <= col_d;
         gate1_q <= gate1_d;
         col1_q <= col1_d;
         show1_q <= show1_d;
         first1_q <= first1_d;
         scanPixel_q <= scanPixel_d;
         scanGate_q <= gate1_q;
         scanCol_q <= col1_q;
         scanShow_q <= show1_q;
         scanFirst_q <= first1_q;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign scanPixel = scanPixel_q;
   assign scanGate = scanGate_q;
   assign scanCol = scanCol_q;
   assign scanShow = scanShow_q;
   assign scanFirst = scanFirst_q;
endmodule // frame_memory_address_counter
`default_nettype wire

// ===== test/frame_memory_address_counter_monitor.sv
// concurrent checks on the bus and scan ports of the frame memory block
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module frame_memory_address_counter_monitor
   import display_map_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [PIX_W-1:0] scanPixel,
   input wire logic [COORD_W-1:0] scanGate,
   input wire logic [7:0] scanCol,
   input wire logic scanShow,
   input wire logic scanFirst
);
   // ****
   // warm-up: the scan pipeline needs a few edges after reset
   // ****
   logic [2:0] warmCnt_q;
   logic [2:0] warmCnt_d;
   always_comb warmCnt_d = (warmCnt_q == 3'h7) ? warmCnt_q : warmCnt_q + 3'h1;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) warmCnt_q <= 3'h0;
      else warmCnt_q <= warmCnt_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence rdTaken;
      hsel && htrans[1] && !hwrite && hready;
   endsequence
   sequence lineEnd;
      scanCol == 8'hEF;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
   a_read_nowait: assert property (rdTaken |=> hreadyout) else $error("read stalled");
   a_col_step: assert property (warmCnt_q == 3'h7 && scanCol != 8'hEF |=>
      scanCol == $past(scanCol) + 8'h01) else $error("scan column skipped");
   a_col_wrap: assert property (lineEnd |=> scanCol == 8'h00) else $error("no line wrap");
   a_scan_range: assert property (scanCol <= 8'hEF && scanGate <= ROW_MAX)
      else $error("scan out of range");
   a_blank_zero: assert property (!scanShow |-> scanPixel == '0)
      else $error("pixel in blank row");
   a_first_home: assert property (scanFirst |-> scanCol == 8'h00 &&
      (scanGate == 9'h000 || scanGate == ROW_MAX)) else $error("frame start misplaced");
   a_first_pulse: assert property (scanFirst |=> !scanFirst [*8])
      else $error("frame start repeats");
endmodule // frame_memory_address_counter_monitor
`default_nettype wire

// ===== test/ahb_host_model.sv
// host side: single-word ahb-lite master that also opens the full screen
// assumes it is called just after a rising edge; hready is our hreadyout
`timescale 1ns/10ps
`default_nettype none
module ahb_host_model
   import display_map_pkg::*;
(
   input wire logic clk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // hsel stays high between transfers so no signal moves twice in one step
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk iff hreadyout === 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? wd : ~hwdata;
      @(posedge clk iff hreadyout === 1'b1);
      rd = hrdata;
   endtask
   task automatic open_full;
      logic [31:0] junk;
      xfer(1'b1, IDX_COL_START, 32'h0, junk);
      xfer(1'b1, IDX_COL_END, 32'hEF, junk);
      xfer(1'b1, IDX_ROW_START, 32'h0, junk);
      xfer(1'b1, IDX_ROW_END, 32'h1AF, junk);
      xfer(1'b1, IDX_VSA_HI, 32'h01, junk);
      xfer(1'b1, IDX_VSA_LO, 32'hB0, junk);
   endtask
endmodule // ahb_host_model
`default_nettype wire

// ===== test/test_frame_memory_address_counter.sv
// bench: registers over ahb-lite, pixels through the window, checked on the scan
// assumes the scan starts at gate 0 after reset and runs one pixel a clock
`timescale 1ns/10ps
`default_nettype none
module test_frame_memory_address_counter
   import display_map_pkg::*;
;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, scanShow, scanFirst;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [PIX_W-1:0] scanPixel;
   logic [COORD_W-1:0] scanGate;
   logic [7:0] scanCol;
   int mismatches = 0;
   int testsRun = 0;
   int cycles = 0;
   int seed;
   logic [17:0] expPix [int];
   localparam logic [5:0] RIDX [7] = '{IDX_CTRL, IDX_COL_END, IDX_ROW_END, IDX_PART_END,
      IDX_VSA_HI, IDX_VSA_LO, 6'h3F};
   localparam logic [31:0] RVAL [7] = '{32'h0, 32'hEF, 32'h1AF, 32'h1AF, 32'h1, 32'hB0, 32'h0};
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ahb_host_model host (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   frame_memory_address_counter u_frame_memory_address_counter (.clk(clk), .arst_n(arst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .scanPixel(scanPixel), .scanGate(scanGate), .scanCol(scanCol),
      .scanShow(scanShow), .scanFirst(scanFirst));
   task automatic check_val(input logic [31:0] got, input logic [31:0] want);
      testsRun++;
      if (got !== want) begin
         mismatches++;
         $display("Error at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic check_pix(input logic [17:0] got, input logic [17:0] want);
      testsRun++;
      if (got !== want) begin
         mismatches++;
         $display("Error at %0t: pixel %h want %h", $time, got, want);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic [31:0] junk;
      host.xfer(1'b1, idx, d, junk);
   endtask
   // expected scan value carries the swap in force when the scan reaches it
   task automatic pixel(input int row, input int col, input logic sw);
      logic [17:0] p;
      p = 18'($urandom);
      expPix[row * 240 + col] = sw ? {p[5:0], p[11:6], p[17:12]} : p;
      wr(IDX_PIXEL, {14'h0, p});
   endtask
   task automatic idle_poll;
      do host.xfer(1'b0, IDX_STATUS, 32'h0, rd); while (rd[STAT_BUSY] !== 1'b0);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (expPix.exists(int'(scanGate) * 240 + int'(scanCol))) begin
         check_pix(scanPixel, expPix[int'(scanGate) * 240 + int'(scanCol)]);
         expPix.delete(int'(scanGate) * 240 + int'(scanCol));
      end
      if (scanCol == 8'h05 && (scanGate == 9'h00A || scanGate == 9'h014))
         check_val({31'h0, scanShow}, {31'h0, scanGate == 9'h014});
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      arst_n = 1'b0;
      seed = $urandom(90750);
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         host.xfer(1'b0, RIDX[i], 32'h0, rd);
         check_val(rd, RVAL[i]);
      end
      $display("reset values done");
      host.open_full();
      wr(IDX_PART_START, 32'h14);
      wr(IDX_PART_END, 32'h40);
      wr(IDX_CTRL, 32'h20);
      wr(IDX_COL_START, 32'h2);
      wr(IDX_COL_END, 32'h3);
      wr(IDX_ROW_START, 32'h14);
      wr(IDX_ROW_END, 32'h15);
      pixel(20, 2, 1'b0);
      pixel(20, 3, 1'b0);
      pixel(21, 2, 1'b0);
      pixel(21, 3, 1'b0);
      idle_poll();
      check_val(rd & 32'h01FF01FF, 32'h00020014);
      $display("window wrap done");
      @(posedge clk iff scanGate == 9'h017);
      wr(IDX_CTRL, 32'h32);
      wr(IDX_COL_START, 32'hA);
      wr(IDX_COL_END, 32'hA);
      wr(IDX_ROW_START, 32'h1E);
      wr(IDX_ROW_END, 32'h1E);
      pixel(30, 229, 1'b1);
      idle_poll();
      wr(IDX_CTRL, 32'h31);
      wr(IDX_COL_START, 32'h20);
      wr(IDX_COL_END, 32'h20);
      wr(IDX_ROW_START, 32'h7);
      wr(IDX_ROW_END, 32'h7);
      pixel(32, 7, 1'b1);
      idle_poll();
      wr(IDX_CTRL, 32'h34);
      wr(IDX_COL_START, 32'h7);
      wr(IDX_COL_END, 32'h7);
      wr(IDX_ROW_START, 32'h18E);
      wr(IDX_ROW_END, 32'h18E);
      pixel(33, 7, 1'b1);
      @(posedge clk iff scanGate == 9'h022);
      check_val(32'(expPix.size()), 32'h0);
      $display("orientation and swap done");
      // pointer 413 with a full scroll area puts memory row 21 on line 40
      wr(IDX_VSP_HI, 32'h1);
      wr(IDX_VSP_LO, 32'h9D);
      wr(IDX_CTRL, 32'h70);
      wr(IDX_COL_START, 32'h2);
      wr(IDX_COL_END, 32'h2);
      wr(IDX_ROW_START, 32'h15);
      wr(IDX_ROW_END, 32'h15);
      pixel(40, 2, 1'b1);
      @(posedge clk iff scanGate == 9'h029);
      check_val(32'(expPix.size()), 32'h0);
      wr(IDX_CTRL, 32'h78);
      repeat (8) @(posedge clk);
      check_val({23'h0, scanGate}, 32'h186);
      $display("scroll and scan direction done");
      report_and_stop();
   end
endmodule // test_frame_memory_address_counter
bind frame_memory_address_counter frame_memory_address_counter_monitor u_mon (.clk(clk),
   .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .scanPixel(scanPixel), .scanGate(scanGate),
   .scanCol(scanCol), .scanShow(scanShow), .scanFirst(scanFirst));
`default_nettype wire
